/* File: bench/sar_host_model.sv */
// Host serial port model: drives control and clock, reads the data pin
`timescale 1ns/10ps
module sar_host_model (
  // Clock
  input  wire logic clock_i,
  // Converter pins
  input  wire logic data_i,
  input  wire logic data_oe_n_i,
  output logic      convert_control_o,
  output logic      sclk_o
);
  logic pin;
  // Pull-up on the data line: a released pin reads high
  assign pin = data_oe_n_i ? 1'b1 : data_i;
  initial begin
    convert_control_o = 1'b1;
    sclk_o = 1'b1;
  end
  // Pins move 1 ns after a clock edge
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Acquire for 360 ns, then hold; clock starts within 5 us
  task automatic start();
    convert_control_o = 1'b1;
    step(36);
    convert_control_o = 1'b0;
    step(2);
  endtask
  // One 140 ns clock period; the bit is read well after the fall
  task automatic fall(output logic d);
    sclk_o = 1'b0;
    step(3);
    d = pin;
    step(4);
    sclk_o = 1'b1;
    step(7);
  endtask
  task automatic set_convert_control(input logic v);
    convert_control_o = v;
    step(2);
  endtask
endmodule

/* File: bench/sar_readout_bench.sv */
// Random and corner-case bench for the serial readout block
`timescale 1ns/10ps
module sar_readout_bench;
  import sar_pkg::*;
  logic        clock_i, rst_n_i, convert_control, sclk, data, oe_n, valid, ready;
  logic        hold, pd, lsb, rv, d;
  logic [11:0] word, res, cur, got, last_res, q[$];
  logic [4:0]  bits, last_bits;
  logic [16:0] lfsr;
  int          n_mismatch, checks;
  // ====
  // Design and host; control, clock and data wired as a serial port
  sar_readout u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .convert_control_i(convert_control), .sclk_i(sclk), .data_o(data),
    .data_oe_n_o(oe_n), .sample_data_i(word), .sample_valid_i(valid),
    .sample_ready_o(ready), .hold_o(hold), .power_down_o(pd),
    .lsb_mode_o(lsb), .result_o(res), .result_bits_o(bits),
    .result_valid_o(rv));
  sar_host_model host (.clock_i(clock_i), .data_i(data),
    .data_oe_n_i(oe_n), .convert_control_o(convert_control), .sclk_o(sclk));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Keep the last reported result; the pulse lasts one cycle
  always @(posedge clock_i) if (rv === 1'b1) begin
    last_res <= res;
    last_bits <= bits;
  end
  function automatic logic [11:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[11:0];
  endfunction
  // Decided top bits of a short result, undecided ones zero
  function automatic logic [11:0] masked(input logic [11:0] w, input int n);
    return w & ~(12'hfff >> n);
  endfunction
  // A hold or abort control fall takes the oldest word, or reuses the held one
  function automatic void take();
    if (q.size() > 0) cur = q.pop_front();
  endfunction
  task automatic cmp(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [11:0] w);
    word = w;
    valid = 1'b1;
    if (ready === 1'b1) q.push_back(w);
    host.step(1);
  endtask
  // Start bit, then n result bits MSB first
  task automatic head(input int n);
    host.fall(d);
    cmp(d, 12'h0);
    cmp(hold, 12'h1);
    for (int i = 11; i > 11 - n; i--) begin
      host.fall(d);
      got[i] = d;
    end
  endtask
  task automatic frame();
    head(12);
    cmp(got, cur);
    host.fall(d);
    cmp(oe_n, 12'h1);
    cmp(pd, 12'h1);
    cmp(last_res, cur);
    cmp(last_bits, 12'hc);
  endtask
  task automatic abort(input int k);
    host.start();
    take();
    head(k - 1);
    host.start();
    cmp(oe_n, 12'h1);
    cmp(last_bits, 12'(k - 1));
    cmp(last_res, masked(cur, k - 1));
    take();
    frame();
  endtask
  task automatic lsb_first();
    host.start();
    take();
    head(11);
    host.set_convert_control(1'b1);
    host.fall(d);
    got[0] = d;
    cmp(got, cur);
    host.set_convert_control(1'b0);
    cmp(oe_n, 12'h1);
    cmp(lsb, 12'h1);
    cmp(pd, 12'h1);
    for (int i = 1; i < 12; i++) begin
      host.fall(d);
      got[i] = d;
    end
    cmp(got, cur);
    host.fall(d);
    cmp(oe_n, 12'h1);
    host.set_convert_control(1'b1);
    cmp(pd, 12'h0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: the tests need about 4400 cycles
  initial begin
    repeat (30000) @(posedge clock_i);
    n_mismatch++;
    conclude();
  end
  // ====
  // Main sequence
  initial begin
    lfsr = 17'h160d0;
    rst_n_i = 1'b0;
    word = 12'h000;
    valid = 1'b0;
    cur = 12'h000;
    repeat (10) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    cmp(oe_n, 12'h1);
    cmp(pd, 12'h0);
    // Ready only rises on the first edge after release
    host.step(1);
    push(12'hfff);
    push(12'h000);
    repeat (14) push(rnd());
    valid = 1'b0;
    host.step(2);
    cmp(ready, 12'h0);
    push(rnd());
    valid = 1'b0;
    $display("buffer fill done");
    for (int t = 0; t < 9; t++) begin
      host.start();
      take();
      frame();
      $display("normal frame %0d done", t);
      // Random valid: a word offered with valid low must not be taken
      word = rnd();
      valid = word[0];
      if (valid && ready === 1'b1) q.push_back(word);
      host.step(1);
      valid = 1'b0;
      if (t % 3 == 0) abort(t == 0 ? 1 : (t == 3 ? 12 : 1 + rnd() % 11));
      if (t % 3 == 1) lsb_first();
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule

/* File: bench/sar_readout_checker.sv */
// Port assertions for the serial readout block
`timescale 1ns/10ps
module sar_readout_checker #(
  parameter int RES_BITS   = 12,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset and host pins
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire logic                convert_control_i,
  input wire logic                sclk_i,
  input wire logic                data_o,
  input wire logic                data_oe_n_o,
  // Sample stream
  input wire logic [RES_BITS-1:0] sample_data_i,
  input wire logic                sample_valid_i,
  input wire logic                sample_ready_o,
  // Status
  input wire logic                hold_o,
  input wire logic                power_down_o,
  input wire logic                lsb_mode_o,
  input wire logic [RES_BITS-1:0] result_o,
  input wire logic [4:0]          result_bits_o,
  input wire logic                result_valid_o
);
  logic [RES_BITS-1:0] low_mask;
  logic [4:0]          lsb_falls;
  // Undecided low bits of a short result
  assign low_mask = {RES_BITS{1'b1}} >> result_bits_o;
  // Clock falls seen during the resend, so the last one is excluded
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) lsb_falls <= 5'h00;
    else if (!lsb_mode_o) lsb_falls <= 5'h00;
    else if (!sclk_i && $past(sclk_i)) lsb_falls <= lsb_falls + 5'h01;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // Sequences and properties
  sequence s_first_fall;
    hold_o && data_oe_n_o && !power_down_o && !lsb_mode_o && $fell(sclk_i);
  endsequence
  sequence s_wake;
    $rose(convert_control_i) && power_down_o;
  endsequence
  AST_HOLD_ON_FALL: assert property ($fell(convert_control_i) && !hold_o &&
    !power_down_o |-> ##[1:2] hold_o) else $error("hold not entered");
  AST_FALL_RELEASE: assert property ($fell(convert_control_i) &&
    !data_oe_n_o |-> ##[1:2] data_oe_n_o) else $error("data not released");
  AST_START_LOW: assert property (s_first_fall |-> ##[1:2]
    (!data_oe_n_o && !data_o)) else $error("start bit not low");
  AST_FULL_POWER: assert property (result_valid_o &&
    result_bits_o == 5'h0c && !convert_control_i |-> ##[0:1] power_down_o)
    else $error("no power-down after full result");
  AST_LOW_BITS_ZERO: assert property (result_valid_o |->
    (result_o & low_mask) == '0) else $error("undecided bits set");
  AST_VALID_PULSE: assert property (result_valid_o |=> !result_valid_o)
    else $error("result valid longer than one cycle");
  AST_LSB_ENTRY: assert property ($rose(lsb_mode_o) |->
    power_down_o && data_oe_n_o) else $error("resend entry wrong");
  AST_LSB_DRIVE: assert property (lsb_mode_o && $fell(sclk_i) &&
    lsb_falls < 5'h0b |-> ##[1:2] !data_oe_n_o) else $error("resend idle");
  AST_WAKE: assert property (s_wake |-> ##[1:2] !power_down_o)
    else $error("no wake on control rise");
  AST_POWER_QUIET: assert property (power_down_o && !lsb_mode_o |->
    data_oe_n_o) else $error("data driven in power-down");
endmodule

bind sar_readout sar_readout_checker #(
  .RES_BITS(RES_BITS), .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .convert_control_i(convert_control_i), .sclk_i(sclk_i), .data_o(data_o),
  .data_oe_n_o(data_oe_n_o), .sample_data_i(sample_data_i),
  .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
  .hold_o(hold_o), .power_down_o(power_down_o), .lsb_mode_o(lsb_mode_o),
  .result_o(result_o), .result_bits_o(result_bits_o),
  .result_valid_o(result_valid_o));

/* File: logic/sar_fifo.sv */
// Sample buffer with parameterised width and depth
`timescale 1ns/10ps
module sar_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Both sides of the buffer
  sar_fifo_if.buffer  fif
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             wr_ready;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_wr_ready;
  logic             push;
  logic             pop;

  // =====================================================================
  // Handshake and pointer arithmetic
  always_comb begin
    push          = fif.wr_valid & wr_ready;
    pop           = fif.rd_ready & (count != '0);
    next_wr_ptr   = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr   = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count    = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
    // Registered ready looks at the next count, so no slot is lost
    next_wr_ready = next_count < (AW+1)'(DEPTH);
  end

  // State registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      wr_ready <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      wr_ready <= next_wr_ready;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= fif.wr_data;
    end
  end

  assign fif.wr_ready = wr_ready;
  assign fif.rd_valid = (count != '0);
  assign fif.rd_data  = mem[rd_ptr];
endmodule

/* File: logic/sar_fifo_if.sv */
// Valid/ready link between the sample buffer and the sequencer
`timescale 1ns/10ps
interface sar_fifo_if #(
  parameter int WIDTH = 12
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  // =====================================================================
  // Buffer side and user side
  modport buffer (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data);
  modport user   (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data);
endinterface

/* File: logic/sar_map.svh */
// Constants for the serial readout block of the sampling converter
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

// =====================================================================
// Conversion sequence, counted in falling edges of the serial clock
`define SAR_RES_BITS    12
`define SAR_START_EDGE  5'h01
`define SAR_LSB_EDGE    5'h0d
`define SAR_END_EDGE    5'h0e
`define SAR_LSB_REPEAT  4'hb

// =====================================================================
// Buffer and reset values
`define SAR_FIFO_DEPTH  16
`define SAR_CODE_RESET  12'h000

`endif

/* File: logic/sar_pkg.sv */
// Types shared by the serial readout modules
package sar_pkg;

  // ===================================================================
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SAR_SAMPLE  = 4'h1,
    SAR_CONVERT = 4'h2,
    SAR_LSB_OUT = 4'h4,
    SAR_POWER   = 4'h8
  } sar_state_type;

endpackage

/* File: logic/sar_readout.sv */
// Conversion sequencer and serial readout of the 12-bit converter
`timescale 1ns/10ps
`include "sar_map.svh"

// Behaviour
// RULE1: High mid-conversion, low in 13th: LSB-first
// RULE2: LSB-first resend over next 11 clocks
// RULE3: LSB-first enters power-down until control rises
// RULE4: High then low before 13th clock aborts
// RULE5: Aborted conversion stops, low bits undecided
// RULE6: Control falling releases data output at once
// RULE7: Host keeps control high until bit captured
// RULE8: Results are unsigned straight binary codes
// RULE9: Control falling switches sampling to hold
// RULE10: Host starts clock within droop limit
// RULE11: Host keeps clock period under maximum
// RULE12: SPI host wiring: select, clock, MISO
// RULE13: DSP port wiring: frame sync, clock, receive
// RULE14: Control low at 13th clock: power-down
// RULE15: Host clock start and period limits
// RULE16: Data driven low marks first cycle
// RULE17: Host holds control high 350 ns first
// RULE18: Twelve bits MSB first, LSB in 13th
module sar_readout
  import sar_pkg::*;
#(
  parameter int RES_BITS   = `SAR_RES_BITS,
  parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  // Host serial pins
  input  wire logic                convert_control_i,
  input  wire logic                sclk_i,
  output logic                     data_o,
  output logic                     data_oe_n_o,
  // Digitised codes from the comparator front end
  input  wire logic [RES_BITS-1:0] sample_data_i,
  input  wire logic                sample_valid_i,
  output logic                     sample_ready_o,
  // Converter status
  output logic                     hold_o,
  output logic                     power_down_o,
  output logic                     lsb_mode_o,
  output logic [RES_BITS-1:0]      result_o,
  output logic [4:0]               result_bits_o,
  output logic                     result_valid_o
);

  // =====================================================================
  // Declarations
  sar_fifo_if #(.WIDTH(RES_BITS)) fif ();

  sar_state_type         state, next_state;
  logic [4:0]            cyc, next_cyc;
  logic [3:0]            lsb_idx, next_lsb_idx;
  logic                  seen_high, next_seen_high;
  logic [RES_BITS-1:0]   held, next_held;
  logic [RES_BITS-1:0]   decided, next_decided;
  logic                  data, next_data;
  logic                  oe_n, next_oe_n;
  logic                  hold, next_hold;
  logic                  pd, next_pd;
  logic [RES_BITS-1:0]   res, next_res;
  logic [4:0]            res_bits, next_res_bits;
  logic                  res_valid, next_res_valid;
  logic                  convert_control_q;
  logic                  sclk_q;
  logic                  convert_control_fall;
  logic                  convert_control_rise;
  logic                  sclk_fall;
  logic                  pop;
  logic [4:0]            k;

  // Result bit presented on falling edge k (MSB at edge 2)
  function automatic logic [3:0] sar_bit_of(input logic [4:0] edge_no);
    sar_bit_of = 4'(`SAR_LSB_EDGE - edge_no);
  endfunction

  // =====================================================================
  // Sample buffer in front of the sequencer
  assign fif.wr_valid = sample_valid_i;
  assign fif.wr_data  = sample_data_i;
  assign fif.rd_ready = pop;

  sar_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .fif     (fif.buffer)
  );

  // Edge detection; pins are synchronous to clock_i
  assign convert_control_fall = convert_control_q & ~convert_control_i;
  assign convert_control_rise = ~convert_control_q & convert_control_i;
  assign sclk_fall = sclk_q & ~sclk_i;
  assign k         = 5'(cyc + 5'h01);

  // =====================================================================
  // Sequencer next-state logic
  always_comb begin
    next_state     = state;
    next_cyc       = cyc;
    next_lsb_idx   = lsb_idx;
    next_seen_high = seen_high;
    next_held      = held;
    next_decided   = decided;
    next_data      = data;
    next_oe_n      = oe_n;
    next_hold      = hold;
    next_pd        = pd;
    next_res       = res;
    next_res_bits  = res_bits;
    next_res_valid = 1'b0;
    pop            = 1'b0;
    case (state)
      SAR_SAMPLE: begin
        next_hold = 1'b0;
        next_pd   = 1'b0;
        if (convert_control_fall) begin
          // Freeze the input for the coming conversion
          next_state     = SAR_CONVERT;                      // [RULE9]
          next_hold      = 1'b1;                             // [RULE9]
          next_cyc       = 5'h00;
          next_seen_high = 1'b0;
          next_decided   = '0;
          pop            = fif.rd_valid;
          next_held      = fif.rd_valid ? fif.rd_data : held;
        end
      end
      SAR_CONVERT: begin
        if (convert_control_i) begin
          next_seen_high = 1'b1;
        end
        if (convert_control_fall && cyc == `SAR_LSB_EDGE) begin
          // Fall during the LSB clock: resend reversed, core sleeps
          next_state   = SAR_LSB_OUT;                        // [RULE1]
          next_lsb_idx = 4'h1;
          next_oe_n    = 1'b1;                               // [RULE6]
          next_pd      = 1'b1;                               // [RULE3]
        end else if (convert_control_fall) begin
          // Abort: report only the bits decided so far, then re-hold
          next_oe_n      = 1'b1;                             // [RULE6]
          next_res       = decided;                          // [RULE5]
          next_res_bits  = (cyc > 5'h01) ? 5'(cyc - 5'h01) : 5'h00;
          next_res_valid = 1'b1;                             // [RULE4]
          next_cyc       = 5'h00;
          next_seen_high = 1'b0;
          next_decided   = '0;
          next_hold      = 1'b1;                             // [RULE9]
          pop            = fif.rd_valid;
          next_held      = fif.rd_valid ? fif.rd_data : held;
        end else if (sclk_fall) begin
          next_cyc = k;
          if (k == `SAR_START_EDGE) begin
            // Leaving high impedance low marks conversion start
            next_oe_n = 1'b0;                                // [RULE16]
            next_data = 1'b0;                                // [RULE16]
          end else if (k <= `SAR_LSB_EDGE) begin
            // Straight binary code, MSB first                   [RULE8]
            next_data = held[sar_bit_of(k)];                 // [RULE18]
            next_decided[sar_bit_of(k)] = held[sar_bit_of(k)];
          end else begin
            next_oe_n      = 1'b1;
            next_res       = decided;
            next_res_bits  = 5'(RES_BITS);
            next_res_valid = 1'b1;
            if (!convert_control_i && !seen_high) begin
              next_state = SAR_POWER;                        // [RULE14]
              next_pd    = 1'b1;                             // [RULE14]
            end else begin
              next_state = SAR_SAMPLE;
              next_hold  = 1'b0;
            end
          end
        end
      end
      SAR_LSB_OUT: begin
        if (convert_control_rise) begin
          // Rising control wins: back to sampling at once
          next_state = SAR_SAMPLE;                           // [RULE3]
          next_oe_n  = 1'b1;
          next_hold  = 1'b0;
          next_pd    = 1'b0;
        end else if (sclk_fall) begin
          if (lsb_idx <= `SAR_LSB_REPEAT) begin
            next_oe_n    = 1'b0;
            next_data    = held[lsb_idx];                    // [RULE2]
            next_lsb_idx = 4'(lsb_idx + 4'h1);
          end else begin
            next_state = SAR_POWER;                          // [RULE3]
            next_oe_n  = 1'b1;
          end
        end
      end
      SAR_POWER: begin
        next_oe_n = 1'b1;
        if (convert_control_rise) begin
          // Power-up and sampling resume together
          next_state = SAR_SAMPLE;                           // [RULE14]
          next_pd    = 1'b0;
          next_hold  = 1'b0;
        end
      end
      default: begin
        next_state = SAR_SAMPLE;
        next_oe_n  = 1'b1;
      end
    endcase
  end

  // =====================================================================
  // Sequencer registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= SAR_SAMPLE;
      cyc       <= 5'h00;
      lsb_idx   <= 4'h0;
      seen_high <= 1'b0;
      held      <= `SAR_CODE_RESET;
      decided   <= `SAR_CODE_RESET;
      data      <= 1'b0;
      oe_n      <= 1'b1;
      hold      <= 1'b0;
      pd        <= 1'b0;
      res       <= `SAR_CODE_RESET;
      res_bits  <= 5'h00;
      res_valid <= 1'b0;
      convert_control_q    <= 1'b1;
      sclk_q    <= 1'b0;
    end else begin
      state     <= next_state;
      cyc       <= next_cyc;
      lsb_idx   <= next_lsb_idx;
      seen_high <= next_seen_high;
      held      <= next_held;
      decided   <= next_decided;
      data      <= next_data;
      oe_n      <= next_oe_n;
      hold      <= next_hold;
      pd        <= next_pd;
      res       <= next_res;
      res_bits  <= next_res_bits;
      res_valid <= next_res_valid;
      convert_control_q    <= convert_control_i;
      sclk_q    <= sclk_i;
    end
  end

  // Outputs straight from flops
  assign data_o         = data;
  assign data_oe_n_o    = oe_n;
  assign hold_o         = hold;
  assign power_down_o   = pd;
  assign lsb_mode_o     = state[2];              // One-hot bit of SAR_LSB_OUT
  assign result_o       = res;
  assign result_bits_o  = res_bits;
  assign result_valid_o = res_valid;
  assign sample_ready_o = fif.wr_ready;
endmodule
